// file: tpw_timer8_pwm.sv
`timescale 1ns/10ps
// Operation
// - fast pwm: action 2 gives non-inverted pwm, action 3 inverted pwm
// - fast pwm: set or clear on match, opposite level on max-to-bottom wrap
// - fast pwm, compare at bottom: one-tick spike every max+1 ticks
// - fast pwm, compare at max: output constant, level set by polarity
// - fast pwm action 1 toggles on every match, compare still buffered
// - phase correct: count up to max, down to bottom; max held one tick
// - phase correct non-inverting: clear on up match, set on down match
// - phase correct: overflow flag set each time count reaches bottom
// - phase correct extremes: bottom holds low, max holds high, inverted opposite
// - counter synchronous to pclk; tick only enables counting and flags
// - waveform mode bits at control bits 6 and 3 pick the sequence
// - force strobe in non-pwm mode forces an immediate match action
// - forced match sets no flag and does not clear counter in ctc
// - force strobe bit always reads back as zero
// - modes: 0 normal, 1 phase correct, 2 ctc with compare top, 3 fast
// - compare update and overflow point per mode as listed
// - phase correct has fixed 8-bit resolution, turning at max
// - non-pwm actions: off, toggle, clear, set on match
// - tick source: stopped, undivided, prescaled taps, external edges
// - count write suppresses compare match on the next tick
// - compare output overrides port when either action bit is set
module tpw_timer8_pwm #(
  parameter int PRESCALE_WIDTH = 10
) (
  input  wire logic        pclk,             // i/o clock, 200 mhz
  input  wire logic        presetn,          // async reset, active low
  input  wire logic [7:0]  paddr,            // apb address
  input  wire logic        psel,             // apb select
  input  wire logic        penable,          // apb enable
  input  wire logic        pwrite,           // apb direction
  input  wire logic [31:0] pwdata,           // apb write data
  output logic      [31:0] prdata,           // apb read data
  output logic             pready,           // apb ready
  output logic             pslverr,          // apb error, unmapped address
  input  wire logic        ext_count_input,  // external count pin
  output logic             compare_output,   // waveform state
  output logic             compare_override, // waveform owns the port pin
  output logic             overflow_flag,    // sticky overflow flag
  output logic             compare_flag      // sticky compare flag
);
  import tpw_pkg::*;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  cnt;
    logic [7:0]  ocr;
    logic [7:0]  ocr_buf;
    logic        dir_down;
    logic        block;
    logic        ovf;
    logic        cmpf;
    logic        out;
    logic        ovr;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tpw_state_type;

  tpw_state_type st_ff;
  tpw_state_type nxt_st;

  logic timer_tick;

  function automatic tpw_wave_type wave_of(input logic [7:0] c);
    return tpw_wave_type'({c[TPW_CTRL_WAVE_HI_BIT], c[TPW_CTRL_WAVE_LO_BIT]});
  endfunction

  function automatic tpw_action_type action_of(input logic [7:0] c);
    return tpw_action_type'({c[TPW_CTRL_ACT_HI_BIT], c[TPW_CTRL_ACT_LO_BIT]});
  endfunction

  function automatic logic apply_action(input tpw_action_type a, input logic o);
    unique case (a)
      TPW_ACT_OFF:    return o;
      TPW_ACT_TOGGLE: return ~o;
      TPW_ACT_CLEAR:  return 1'b0;
      TPW_ACT_SET:    return 1'b1;
    endcase
  endfunction

  function automatic logic is_pwm(input tpw_wave_type w);
    return (w == TPW_WAVE_PHASE) || (w == TPW_WAVE_FAST);
  endfunction

  tpw_tick_gen #(
    .PRESCALE_WIDTH (PRESCALE_WIDTH)
  ) u_tick (
    .pclk            (pclk),
    .presetn         (presetn),
    .tick_source_sel (tpw_source_type'(st_ff.ctrl[TPW_CTRL_SRC_MSB:TPW_CTRL_SRC_LSB])),
    .ext_count_input (ext_count_input),
    .timer_tick      (timer_tick)
  );

  tpw_wave_type   wave;
  tpw_action_type act;
  logic [7:0]     cmp;
  logic           hit;
  logic           setup;
  logic           wr;
  logic           ovf_ev;
  logic           cmp_ev;

  always_comb begin
    nxt_st = st_ff;
    wave   = wave_of(st_ff.ctrl);
    act    = action_of(st_ff.ctrl);
    cmp    = is_pwm(wave) ? st_ff.ocr_buf : st_ff.ocr;
    hit    = (st_ff.cnt == cmp) && !st_ff.block;
    setup  = psel && !penable;
    wr     = psel && penable && st_ff.pready && pwrite;
    ovf_ev = 1'b0;
    cmp_ev = 1'b0;

    // no wait state: ready is raised in the first access cycle only
    nxt_st.pready = setup;
    if (setup) begin
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata  = '0;
      unique case (paddr)
        TPW_ADDR_CONTROL: nxt_st.prdata[7:0] = st_ff.ctrl & ~TPW_FORCE_MASK;
        TPW_ADDR_COUNT:   nxt_st.prdata[7:0] = st_ff.cnt;
        TPW_ADDR_COMPARE: nxt_st.prdata[7:0] = st_ff.ocr;
        TPW_ADDR_FLAGS: begin
          nxt_st.prdata[TPW_FLAG_OVF_BIT] = st_ff.ovf;
          nxt_st.prdata[TPW_FLAG_CMP_BIT] = st_ff.cmpf;
        end
        default:          nxt_st.pslverr = 1'b1;
      endcase
    end

    // counting advances only on a tick, never on its own clock
    if (timer_tick) begin
      nxt_st.block = 1'b0;
      unique case (wave)
        TPW_WAVE_NORMAL: begin
          nxt_st.cnt = st_ff.cnt + TPW_COUNT_STEP;
          ovf_ev     = (st_ff.cnt == TPW_COUNT_MAX);
          if (hit) begin
            cmp_ev     = 1'b1;
            nxt_st.out = apply_action(act, st_ff.out);
          end
        end
        TPW_WAVE_CTC: begin
          nxt_st.cnt = hit ? TPW_COUNT_BOTTOM : st_ff.cnt + TPW_COUNT_STEP;
          ovf_ev     = (st_ff.cnt == TPW_COUNT_MAX) && !hit;
          if (hit) begin
            cmp_ev     = 1'b1;
            nxt_st.out = apply_action(act, st_ff.out);
          end
        end
        TPW_WAVE_FAST: begin
          nxt_st.cnt = st_ff.cnt + TPW_COUNT_STEP;
          if (hit) begin
            cmp_ev = 1'b1;
            if (act == TPW_ACT_TOGGLE) begin
              nxt_st.out = ~st_ff.out;
            end else if (act == TPW_ACT_CLEAR || act == TPW_ACT_SET) begin
              nxt_st.out = (act == TPW_ACT_SET);
            end
          end
          // for clear and set actions the wrap overrides a match at max, so compare at max stays constant
          if (st_ff.cnt == TPW_COUNT_MAX) begin
            ovf_ev         = 1'b1;
            nxt_st.ocr_buf = st_ff.ocr;
            if (act == TPW_ACT_CLEAR || act == TPW_ACT_SET) begin
              nxt_st.out = (act == TPW_ACT_CLEAR);
            end
          end
        end
        TPW_WAVE_PHASE: begin
          if (!st_ff.dir_down) begin
            if (st_ff.cnt == TPW_COUNT_MAX) begin
              nxt_st.dir_down = 1'b1;
              nxt_st.cnt      = st_ff.cnt - TPW_COUNT_STEP;
              nxt_st.ocr_buf  = st_ff.ocr;
            end else begin
              nxt_st.cnt = st_ff.cnt + TPW_COUNT_STEP;
            end
          end else if (st_ff.cnt == TPW_COUNT_BOTTOM) begin
            nxt_st.dir_down = 1'b0;
            nxt_st.cnt      = st_ff.cnt + TPW_COUNT_STEP;
            ovf_ev          = 1'b1;
          end else begin
            nxt_st.cnt = st_ff.cnt - TPW_COUNT_STEP;
          end
          if (hit) begin
            cmp_ev = 1'b1;
            if (act == TPW_ACT_CLEAR || act == TPW_ACT_SET) begin
              if (cmp == TPW_COUNT_MAX) begin
                nxt_st.out = (act == TPW_ACT_CLEAR);
              end else if (cmp == TPW_COUNT_BOTTOM) begin
                nxt_st.out = (act == TPW_ACT_SET);
              end else begin
                nxt_st.out = st_ff.dir_down ? (act == TPW_ACT_CLEAR) : (act == TPW_ACT_SET);
              end
            end
          end
        end
      endcase
    end

    if (wr && paddr == TPW_ADDR_CONTROL) begin
      nxt_st.ctrl = pwdata[7:0] & ~TPW_FORCE_MASK;
      // the strobe acts with the action bits written alongside it, so one write forces the new action
      if (pwdata[TPW_CTRL_FORCE_BIT] && !is_pwm(wave_of(pwdata[7:0]))) begin
        nxt_st.out = apply_action(action_of(pwdata[7:0]), st_ff.out);
      end
    end
    if (wr && paddr == TPW_ADDR_COUNT) begin
      nxt_st.cnt   = pwdata[7:0];
      nxt_st.block = 1'b1;
    end
    if (wr && paddr == TPW_ADDR_COMPARE) begin
      nxt_st.ocr = pwdata[7:0];
    end
    if (!is_pwm(wave_of(nxt_st.ctrl))) begin
      nxt_st.ocr_buf = nxt_st.ocr;
    end

    // a flag event in the clearing cycle survives the clear
    nxt_st.ovf  = ovf_ev | (st_ff.ovf &
                  !(wr && paddr == TPW_ADDR_FLAGS && pwdata[TPW_FLAG_OVF_BIT]));
    nxt_st.cmpf = cmp_ev | (st_ff.cmpf &
                  !(wr && paddr == TPW_ADDR_FLAGS && pwdata[TPW_FLAG_CMP_BIT]));
    nxt_st.ovr  = nxt_st.ctrl[TPW_CTRL_ACT_HI_BIT] | nxt_st.ctrl[TPW_CTRL_ACT_LO_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata           = st_ff.prdata;
  assign pready           = st_ff.pready;
  assign pslverr          = st_ff.pslverr;
  assign compare_output   = st_ff.out;
  assign compare_override = st_ff.ovr;
  assign overflow_flag    = st_ff.ovf;
  assign compare_flag     = st_ff.cmpf;

  logic cnt_wr;
  logic ctl_wr;
  assign cnt_wr = wr && paddr == TPW_ADDR_COUNT;
  assign ctl_wr = wr && paddr == TPW_ADDR_CONTROL;

  a_fast_wrap_set: assert property (@(posedge pclk) disable iff (!presetn)
    timer_tick && wave == TPW_WAVE_FAST && act == TPW_ACT_CLEAR && st_ff.cnt == TPW_COUNT_MAX && !ctl_wr
    |=> compare_output && st_ff.cnt == TPW_COUNT_BOTTOM)
    else $error("fast pwm non-inverted output not set at wrap");

  a_fast_inv_clear: assert property (@(posedge pclk) disable iff (!presetn)
    timer_tick && wave == TPW_WAVE_FAST && act == TPW_ACT_SET && st_ff.cnt == TPW_COUNT_MAX && !ctl_wr
    |=> !compare_output)
    else $error("fast pwm inverted output not cleared at wrap");

  a_phase_max_hold: assert property (@(posedge pclk) disable iff (!presetn)
    timer_tick && wave == TPW_WAVE_PHASE && !st_ff.dir_down && st_ff.cnt == TPW_COUNT_MAX && !cnt_wr
    |=> st_ff.dir_down && st_ff.cnt == TPW_COUNT_MAX - TPW_COUNT_STEP)
    else $error("phase correct count did not turn down after max");

  a_phase_bottom_ovf: assert property (@(posedge pclk) disable iff (!presetn)
    timer_tick && wave == TPW_WAVE_PHASE && st_ff.dir_down && st_ff.cnt == TPW_COUNT_BOTTOM
    |=> overflow_flag && !st_ff.dir_down)
    else $error("phase correct overflow not flagged at bottom");

  a_fast_max_ovf: assert property (@(posedge pclk) disable iff (!presetn)
    timer_tick && wave == TPW_WAVE_FAST && st_ff.cnt == TPW_COUNT_MAX
    |=> overflow_flag && st_ff.ocr_buf == $past(st_ff.ocr))
    else $error("fast pwm overflow or buffer load missing at max");

  a_tick_gates_count: assert property (@(posedge pclk) disable iff (!presetn)
    !timer_tick && !cnt_wr |=> st_ff.cnt == $past(st_ff.cnt))
    else $error("count moved without a tick");

  a_force_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_wr && pwdata[TPW_CTRL_FORCE_BIT] && !timer_tick && !compare_flag && !cnt_wr
    |=> !compare_flag && st_ff.cnt == $past(st_ff.cnt))
    else $error("forced compare touched flag or count");

  a_force_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == TPW_ADDR_CONTROL |=> pready && !prdata[TPW_CTRL_FORCE_BIT])
    else $error("force strobe read back as one");

  a_write_blocks_match: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_wr ##1 (timer_tick && !cnt_wr && !compare_flag)
    |=> !compare_flag)
    else $error("compare match not suppressed after count write");

  a_override_follows: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_wr |=> compare_override == (pwdata[TPW_CTRL_ACT_HI_BIT] | pwdata[TPW_CTRL_ACT_LO_BIT])
               ##1 compare_override == (act != TPW_ACT_OFF))
    else $error("port override does not follow action bits");

endmodule

// file: tpw_pkg.sv
package tpw_pkg;

  // register byte addresses on the apb bus
  localparam logic [7:0] TPW_ADDR_CONTROL = 8'h00;
  localparam logic [7:0] TPW_ADDR_COUNT   = 8'h04;
  localparam logic [7:0] TPW_ADDR_COMPARE = 8'h08;
  localparam logic [7:0] TPW_ADDR_FLAGS   = 8'h0c;

  // timer_control field positions
  localparam int TPW_CTRL_FORCE_BIT   = 7;
  localparam int TPW_CTRL_WAVE_LO_BIT = 6;
  localparam int TPW_CTRL_ACT_HI_BIT  = 5;
  localparam int TPW_CTRL_ACT_LO_BIT  = 4;
  localparam int TPW_CTRL_WAVE_HI_BIT = 3;
  localparam int TPW_CTRL_SRC_MSB     = 2;
  localparam int TPW_CTRL_SRC_LSB     = 0;

  // flags register field positions, write one to clear
  localparam int TPW_FLAG_OVF_BIT = 0;
  localparam int TPW_FLAG_CMP_BIT = 1;

  localparam logic [7:0] TPW_CTRL_RESET  = 8'h00;
  localparam logic [7:0] TPW_FORCE_MASK  = 8'h80;
  localparam logic [7:0] TPW_COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] TPW_COUNT_MAX    = 8'hff;
  localparam logic [7:0] TPW_COUNT_STEP   = 8'h01;

  // prescaler tap exponents
  localparam int TPW_DIV8_LOG    = 3;
  localparam int TPW_DIV64_LOG   = 6;
  localparam int TPW_DIV256_LOG  = 8;
  localparam int TPW_DIV1024_LOG = 10;

  typedef enum logic [1:0] {
    TPW_WAVE_NORMAL,
    TPW_WAVE_PHASE,
    TPW_WAVE_CTC,
    TPW_WAVE_FAST
  } tpw_wave_type;

  typedef enum logic [1:0] {
    TPW_ACT_OFF,
    TPW_ACT_TOGGLE,
    TPW_ACT_CLEAR,
    TPW_ACT_SET
  } tpw_action_type;

  typedef enum logic [2:0] {
    TPW_SRC_STOP,
    TPW_SRC_DIV1,
    TPW_SRC_DIV8,
    TPW_SRC_DIV64,
    TPW_SRC_DIV256,
    TPW_SRC_DIV1024,
    TPW_SRC_EXT_FALL,
    TPW_SRC_EXT_RISE
  } tpw_source_type;

endpackage

// file: tpw_tick_gen.sv
`timescale 1ns/10ps
module tpw_tick_gen #(
  parameter int PRESCALE_WIDTH = 10
) (
  input  wire logic                    pclk,            // i/o clock
  input  wire logic                    presetn,         // async reset, active low
  input  wire tpw_pkg::tpw_source_type tick_source_sel, // tick source choice
  input  wire logic                    ext_count_input, // external count pin
  output logic                         timer_tick       // one-cycle tick enable
);
  import tpw_pkg::*;

  if (PRESCALE_WIDTH < TPW_DIV1024_LOG) begin : g_width_check
    $error("prescaler too narrow for the divide-by-1024 tap");
  end

  typedef struct packed {
    logic [PRESCALE_WIDTH-1:0] prescale;
    logic                      ext_prev;
    logic                      tick;
  } tpw_tick_state_type;

  tpw_tick_state_type tick_ff;
  tpw_tick_state_type nxt_tick;

  function automatic logic tap_due(input logic [PRESCALE_WIDTH-1:0] p, input int lg);
    logic [PRESCALE_WIDTH-1:0] m;
    m = PRESCALE_WIDTH'((1 << lg) - 1);
    return (p & m) == m;
  endfunction

  always_comb begin
    nxt_tick          = tick_ff;
    nxt_tick.prescale = tick_ff.prescale + PRESCALE_WIDTH'(1);
    nxt_tick.ext_prev = ext_count_input;
    unique case (tick_source_sel)
      TPW_SRC_STOP:     nxt_tick.tick = 1'b0;
      TPW_SRC_DIV1:     nxt_tick.tick = 1'b1;
      TPW_SRC_DIV8:     nxt_tick.tick = tap_due(tick_ff.prescale, TPW_DIV8_LOG);
      TPW_SRC_DIV64:    nxt_tick.tick = tap_due(tick_ff.prescale, TPW_DIV64_LOG);
      TPW_SRC_DIV256:   nxt_tick.tick = tap_due(tick_ff.prescale, TPW_DIV256_LOG);
      TPW_SRC_DIV1024:  nxt_tick.tick = tap_due(tick_ff.prescale, TPW_DIV1024_LOG);
      TPW_SRC_EXT_FALL: nxt_tick.tick = tick_ff.ext_prev & ~ext_count_input;
      TPW_SRC_EXT_RISE: nxt_tick.tick = ~tick_ff.ext_prev & ext_count_input;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_ff <= '0;
    end else begin
      tick_ff <= nxt_tick;
    end
  end

  assign timer_tick = tick_ff.tick;

endmodule

// file: tpw_pin_model.sv
`timescale 1ns/10ps
module tpw_pin_model (
  input  wire logic compare_output,   // waveform state
  input  wire logic compare_override, // waveform owns the pin
  input  wire logic dir_out,          // port direction, 1 drives
  input  wire logic port_data,        // port data latch
  output logic      pin               // pad level
);
  // pad is pulled up while no driver is on, so a stale level never shows
  assign pin = !dir_out ? 1'b1 : compare_override ? compare_output : port_data;
endmodule

// file: timer8_pwm_waveform_unit_test.sv
`timescale 1ns/10ps
module timer8_pwm_waveform_unit_test;
  import tpw_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, ext_count_input, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, compare_output, compare_override, overflow_flag, compare_flag;
  logic        dir_out, port_data, pin;
  int          n_fail, checked, cycles, seed, ext_cnt, k, act;

  tpw_timer8_pwm tpw_timer8_pwm_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_input(ext_count_input), .compare_output(compare_output),
    .compare_override(compare_override), .overflow_flag(overflow_flag), .compare_flag(compare_flag));
  tpw_pin_model tpw_pin_model_inst (.compare_output(compare_output), .compare_override(compare_override),
    .dir_out(dir_out), .port_data(port_data), .pin(pin));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // external count pin: one rise and one fall every four cycles
  always @(posedge pclk) begin
    ext_cnt <= ext_cnt + 1;
    ext_count_input <= ext_cnt[1];
  end

  // all tests need well under 50k cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: register read %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: output %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic cmp_len(input int got, input int exp);
    checked++;
    if (got != exp) begin
      n_fail++;
      $display("Error at %0t: run length %0d, expected %0d", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge pclk);
    paddr  <= a;
    pwrite <= w;
    pwdata <= {24'h000000, d};
    psel   <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // the slave answers in the first access cycle, with no wait state
    cmp_len(n, 1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    apb(a, 1'b0, 8'h00);
    cmp_reg(rd[7:0], exp);
  endtask

  function automatic logic [7:0] ctl(input int mode, input int a, input int src, input logic frc);
    ctl = {frc, mode[0], a[1:0], mode[1], src[2:0]};
  endfunction

  // reference waveform in ticks: high and low runs, or kst >= 0 for a steady level
  task automatic model_wave(input int mode, input int a, input int cv, output int h, output int l,
                            output int kst);
    kst = -1;
    h = 0;
    if (mode == 3 && a == 1) h = 256;
    else if (mode == 2) h = cv + 1;
    else if (mode == 3 && cv == 255) kst = (a == 2);
    else if (mode == 3) h = (a == 2) ? cv + 1 : 255 - cv;
    else if (cv == 0 || cv == 255) kst = ((cv == 255) == (a == 2));
    else h = (a == 2) ? 2 * cv : 510 - 2 * cv;
    l = (mode == 3 && a != 1) ? 256 - h : (mode == 1) ? 510 - h : h;
  endtask

  task automatic wait_lvl(input logic v);
    int n;
    n = 0;
    while (compare_output !== v && n < 20000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic run_len(input logic v, output int len);
    len = 0;
    while (compare_output === v && len < 20000) begin
      @(posedge pclk);
      len++;
    end
  endtask

  task automatic run_wave(input int mode, input int a, input int cv, input int src, input int dv);
    int h, l, kst, got, n;
    model_wave(mode, a, cv, h, l, kst);
    wr(TPW_ADDR_CONTROL, 8'h00);
    wr(TPW_ADDR_COMPARE, cv[7:0]);
    wr(TPW_ADDR_COUNT, 8'h00);
    wr(TPW_ADDR_CONTROL, ctl(mode, a, src, 1'b0));
    if (kst >= 0) begin
      // first pass lets the output reach its steady level
      repeat (600 * dv) @(posedge pclk);
      n = 0;
      repeat (600 * dv) begin
        @(posedge pclk);
        if (compare_output !== kst[0]) n++;
      end
      cmp_len(n, 0);
    end else begin
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      run_len(1'b1, got);
      cmp_len(got, h * dv);
      run_len(1'b0, got);
      cmp_len(got, l * dv);
    end
    cmp_bit(pin, compare_output);
    $display("wave mode %0d action %0d compare %0d source %0d done", mode, a, cv, src);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    dir_out = 1'b1;
    port_data = 1'b0;
    ext_cnt = 0;
    ext_count_input = 1'b0;
    n_fail = 0;
    checked = 0;
    cycles = 0;
    seed = 60;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(TPW_ADDR_CONTROL, TPW_CTRL_RESET);
    rdchk(TPW_ADDR_COUNT, 8'h00);
    cmp_bit(compare_output, 1'b0);
    apb(8'h10, 1'b0, 8'h00);
    cmp_bit(err, 1'b1);
    cmp_reg(rd[7:0], 8'h00);
    $display("reset and decode test done");
    // ctc with the tick stopped: set, clear, toggle, toggle
    wr(TPW_ADDR_COMPARE, 8'h05);
    wr(TPW_ADDR_COUNT, 8'h05);
    for (k = 0; k < 4; k++) begin
      act = (k < 2) ? 3 - k : 1;
      wr(TPW_ADDR_CONTROL, ctl(2, act, 0, 1'b1));
      @(posedge pclk);
      cmp_bit(compare_output, k == 0 || k == 2);
      cmp_bit(compare_override, 1'b1);
      rdchk(TPW_ADDR_CONTROL, ctl(2, act, 0, 1'b0));
    end
    rdchk(TPW_ADDR_COUNT, 8'h05);
    cmp_bit(compare_flag, 1'b0);
    wr(TPW_ADDR_CONTROL, 8'h00);
    @(posedge pclk);
    cmp_bit(compare_override, 1'b0);
    cmp_bit(pin, port_data);
    // with the driver off the pad must fall back to its pull-up
    dir_out <= 1'b0;
    @(posedge pclk);
    cmp_bit(pin, 1'b1);
    dir_out <= 1'b1;
    $display("forced compare test done");
    wr(TPW_ADDR_CONTROL, ctl(0, 0, 1, 1'b0));
    wr(TPW_ADDR_FLAGS, 8'h03);
    repeat (300) @(posedge pclk);
    rdchk(TPW_ADDR_FLAGS, 8'h03);
    wr(TPW_ADDR_COMPARE, 8'h20);
    wr(TPW_ADDR_COUNT, 8'h80);
    wr(TPW_ADDR_FLAGS, 8'h03);
    wr(TPW_ADDR_COUNT, 8'h20);
    rdchk(TPW_ADDR_FLAGS, 8'h00);
    wr(TPW_ADDR_CONTROL, ctl(2, 0, 1, 1'b0));
    wr(TPW_ADDR_COMPARE, 8'h0a);
    wr(TPW_ADDR_COUNT, 8'h00);
    wr(TPW_ADDR_FLAGS, 8'h03);
    repeat (300) @(posedge pclk);
    rdchk(TPW_ADDR_FLAGS, 8'h02);
    cmp_bit(overflow_flag, 1'b0);
    wr(TPW_ADDR_CONTROL, ctl(1, 0, 1, 1'b0));
    wr(TPW_ADDR_FLAGS, 8'h03);
    repeat (600) @(posedge pclk);
    cmp_bit(overflow_flag, 1'b1);
    $display("flag test done");
    run_wave(3, 2, 64, 1, 1);
    run_wave(3, 3, 64, 1, 1);
    run_wave(3, 2, 0, 1, 1);
    run_wave(3, 2, 255, 1, 1);
    run_wave(3, 3, 255, 1, 1);
    run_wave(3, 1, 0, 1, 1);
    run_wave(1, 2, 64, 1, 1);
    run_wave(1, 3, 64, 1, 1);
    run_wave(1, 2, 0, 1, 1);
    run_wave(1, 2, 255, 1, 1);
    run_wave(1, 3, 0, 1, 1);
    run_wave(2, 1, 0, 1, 1);
    run_wave(2, 1, 9, 1, 1);
    run_wave(3, 2, 127, 2, 8);
    run_wave(3, 2, 127, 6, 4);
    run_wave(3, 2, 127, 7, 4);
    for (k = 0; k < 2; k++) begin
      run_wave(3, 2, 1 + (($random(seed) & 255) % 254), 1, 1);
    end
    complete_run();
  end
endmodule
